// ---- hdl/dhp_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port #(
    parameter int unsigned BURST_CYCLES = dhp_pkg::BURST_CYC
) (
    input  wire logic                   CORE_CLK_IN,
    input  wire logic                   RST_IN,
    input  wire logic                   CLK_EN_IN,
    input  wire logic                   CS_N_IN,
    input  wire logic                   REGISTER_SELECT_LINE_IN,
    input  wire logic                   WR_N_IN,
    input  wire logic                   RD_N_IN,
    input  wire logic [dhp_pkg::DW-1:0] DATA_IN,
    output logic      [dhp_pkg::DW-1:0] DATA_OUT,
    output logic                        DATA_OE_OUT,
    input  wire logic                   RX_VALID_IN,
    input  wire logic [dhp_pkg::DW-1:0] RX_CODE_IN,
    input  wire logic                   DELAYED_STEER_IN,
    input  wire logic                   CP_SQUARE_IN,
    output logic                        EVENT_OR_TONE_PIN_OUT,
    output logic                        EVENT_OR_TONE_PIN_OE_OUT,
    output logic      [dhp_pkg::DW-1:0] TONE_CODE_OUT,
    output logic                        TONE_OUTPUT_ON_OUT,
    output logic                        SINGLE_TONE_OUT,
    output logic                        COLUMN_SEL_OUT,
    output logic                        DETECT_EN_OUT
);
    import dhp_pkg::*;

    dhp_ctrl_a_s      control_reg_a;
    dhp_ctrl_b_s      control_reg_b;
    dhp_status_s      status_reg;
    dhp_status_s      status_next;
    logic [DW-1:0]    rx_data_reg;
    logic             wr_idle_reg;
    logic             rd_idle_reg;
    logic             wr_take;
    logic             rd_take;
    logic             burst_en;
    logic             rx_take;
    logic             burst_active;
    logic             burst_done;
    logic             pin_low;

    // a strobe is taken on its falling edge, so one host cycle is one access
    assign wr_take    = !CS_N_IN && !WR_N_IN && wr_idle_reg;
    assign rd_take    = !CS_N_IN && !RD_N_IN && rd_idle_reg;
    assign burst_en   = !control_reg_b.burst_off;
    assign rx_take    = RX_VALID_IN && !control_reg_a.cp_sel;

    logic dec_stat;
    logic dec_tx;
    logic dec_ctrl;
    always_comb begin
        dec_stat = 1'b0;
        dec_tx   = 1'b0;
        dec_ctrl = 1'b0;
        if (rd_take && REGISTER_SELECT_LINE_IN == RS_CTRL) begin
            dec_stat = 1'b1;
        end else if (wr_take && REGISTER_SELECT_LINE_IN == RS_DATA) begin
            dec_tx = 1'b1;
        end else if (wr_take && REGISTER_SELECT_LINE_IN == RS_CTRL) begin
            dec_ctrl = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            wr_idle_reg <= 1'b0;
            rd_idle_reg <= 1'b0;
        end else if (CLK_EN_IN) begin
            wr_idle_reg <= CS_N_IN || WR_N_IN;
            rd_idle_reg <= CS_N_IN || RD_N_IN;
        end
    end

    // shared control address: bank bit steers exactly one following write
    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            control_reg_a <= CTRL_A_RST;
            control_reg_b <= CTRL_B_RST;
        end else if (CLK_EN_IN && dec_ctrl) begin
            if (control_reg_a.bank_sel) begin
                control_reg_b          <= DATA_IN;
                control_reg_a.bank_sel <= 1'b0;
            end else begin
                control_reg_a <= DATA_IN;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            TONE_CODE_OUT <= DATA_RST;
        end else if (CLK_EN_IN && dec_tx) begin
            TONE_CODE_OUT <= DATA_IN;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            rx_data_reg <= DATA_RST;
        end else if (CLK_EN_IN && rx_take) begin
            rx_data_reg <= RX_CODE_IN;
        end
    end

    // a flag set in the same cycle as the status read survives the clear
    always_comb begin
        status_next       = status_reg;
        status_next.steer = DELAYED_STEER_IN;
        if (dec_stat) begin
            status_next.irq      = 1'b0;
            status_next.tx_empty = 1'b0;
            status_next.rx_full  = 1'b0;
        end
        if (!burst_en) begin
            status_next.tx_empty = 1'b0;
        end
        if (burst_done && burst_en) begin
            status_next.tx_empty = 1'b1;
            status_next.irq      = 1'b1;
        end
        if (rx_take) begin
            status_next.rx_full = 1'b1;
            status_next.irq     = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            status_reg <= '0;
        end else if (CLK_EN_IN) begin
            status_reg <= status_next;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            DATA_OUT    <= DATA_RST;
            DATA_OE_OUT <= 1'b0;
        end else if (CLK_EN_IN) begin
            DATA_OE_OUT <= !CS_N_IN && !RD_N_IN;
            if (rd_take) begin
                DATA_OUT <= (REGISTER_SELECT_LINE_IN == RS_CTRL) ?
                            {DELAYED_STEER_IN, status_reg.rx_full,
                             status_reg.tx_empty, status_reg.irq} : rx_data_reg;
            end
        end
    end

    dhp_burst_timer #(
        .CYCLES(BURST_CYCLES)
    ) u_timer (
        .clk_in   (CORE_CLK_IN),
        .rst_in   (RST_IN),
        .ce_in    (CLK_EN_IN),
        .start_in (dec_tx && burst_en),
        .double_in(control_reg_a.cp_sel),
        .burst_out(burst_active),
        .done_out (burst_done)
    );

    // pin only ever pulls low; the external pull-up gives the high level
    always_comb begin
        pin_low = 1'b0;
        if (control_reg_a.cp_sel) begin
            pin_low = control_reg_a.irq_en && !CP_SQUARE_IN;
        end else if (control_reg_b.test_mode) begin
            pin_low = !DELAYED_STEER_IN;
        end else if (control_reg_a.irq_en) begin
            pin_low = status_next.irq;
        end
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RST_IN) begin
            EVENT_OR_TONE_PIN_OUT    <= 1'b0;
            EVENT_OR_TONE_PIN_OE_OUT <= 1'b0;
            TONE_OUTPUT_ON_OUT       <= 1'b0;
            SINGLE_TONE_OUT          <= 1'b0;
            COLUMN_SEL_OUT           <= 1'b0;
            DETECT_EN_OUT            <= 1'b0;
        end else if (CLK_EN_IN) begin
            EVENT_OR_TONE_PIN_OUT    <= 1'b0;
            EVENT_OR_TONE_PIN_OE_OUT <= pin_low;
            TONE_OUTPUT_ON_OUT       <= control_reg_a.tone_on &&
                                        (!burst_en || burst_active);
            SINGLE_TONE_OUT          <= control_reg_b.single_tone;
            COLUMN_SEL_OUT           <= control_reg_b.column_sel;
            DETECT_EN_OUT            <= !control_reg_a.cp_sel;
        end
    end

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (RST_IN);

    chk_bank_route: assert property (
        (CLK_EN_IN && dec_ctrl && !control_reg_a.bank_sel)
        |=> control_reg_a == $past(DATA_IN))
        else $error("control A write not stored");
    chk_bank_b_once: assert property (
        (CLK_EN_IN && dec_ctrl && control_reg_a.bank_sel)
        |=> control_reg_b == $past(DATA_IN) && !control_reg_a.bank_sel)
        else $error("control B write not routed once");
    chk_tx_latch: assert property (
        (CLK_EN_IN && dec_tx) |=> TONE_CODE_OUT == $past(DATA_IN))
        else $error("tone code not latched");
    chk_tx_hold: assert property (
        !(CLK_EN_IN && dec_tx) |=> $stable(TONE_CODE_OUT))
        else $error("tone code not held");
    chk_rx_gated: assert property (
        (CLK_EN_IN && RX_VALID_IN && control_reg_a.cp_sel)
        |=> rx_data_reg == $past(rx_data_reg) && !$rose(status_reg.rx_full))
        else $error("digit decoded in call-progress mode");
    chk_status_clear: assert property (
        (CLK_EN_IN && dec_stat && !rx_take && !burst_done)
        |=> status_reg[2:0] == 3'h0)
        else $error("status read did not clear flags");
    chk_set_wins: assert property (
        (CLK_EN_IN && dec_stat && rx_take) |=> status_reg.rx_full && status_reg.irq)
        else $error("flag lost on simultaneous read");
    chk_irq_pin: assert property (
        (CLK_EN_IN && rx_take && control_reg_a.irq_en && !control_reg_b.test_mode)
        |=> EVENT_OR_TONE_PIN_OE_OUT)
        else $error("interrupt pin not pulled low");
    chk_cp_square: assert property (
        (CLK_EN_IN && control_reg_a.cp_sel && control_reg_a.irq_en)
        |=> EVENT_OR_TONE_PIN_OE_OUT == !$past(CP_SQUARE_IN))
        else $error("call-progress square not on pin");
    chk_tone_gate: assert property (
        (CLK_EN_IN && !control_reg_a.tone_on) |=> !TONE_OUTPUT_ON_OUT)
        else $error("tone on while output disabled");
    chk_tx_ready: assert property (
        (CLK_EN_IN && burst_done && burst_en) |=> status_reg.tx_empty && status_reg.irq)
        else $error("transmit ready not flagged");
    chk_read_data: assert property (
        (CLK_EN_IN && rd_take && REGISTER_SELECT_LINE_IN == RS_DATA)
        |=> DATA_OE_OUT && DATA_OUT == $past(rx_data_reg))
        else $error("receive data read not answered");

    cov_bank_b: cover property (CLK_EN_IN && dec_ctrl && control_reg_a.bank_sel);
    cov_burst_cp: cover property (burst_active && control_reg_a.cp_sel);
    cov_read_clear: cover property (CLK_EN_IN && dec_stat && status_reg.irq);
endmodule
`default_nettype wire

// ---- hdl/dhp_pkg.sv ----
package dhp_pkg;
    localparam int unsigned CLK_HZ    = 10_000_000;
    localparam int unsigned BURST_MS  = 51;
    localparam int unsigned BURST_CYC = BURST_MS * (CLK_HZ / 1000);
    localparam int unsigned CNT_W     = 21;
    localparam int unsigned DW        = 4;
    localparam logic        RS_DATA   = 1'b0;
    localparam logic        RS_CTRL   = 1'b1;

    typedef struct packed {
        logic bank_sel;
        logic irq_en;
        logic cp_sel;
        logic tone_on;
    } dhp_ctrl_a_s;

    typedef struct packed {
        logic column_sel;
        logic single_tone;
        logic test_mode;
        logic burst_off;
    } dhp_ctrl_b_s;

    typedef struct packed {
        logic steer;
        logic rx_full;
        logic tx_empty;
        logic irq;
    } dhp_status_s;

    localparam dhp_ctrl_a_s CTRL_A_RST = 4'h0;
    localparam dhp_ctrl_b_s CTRL_B_RST = 4'h0;
    localparam logic [DW-1:0] DATA_RST = 4'h0;

    typedef enum logic [2:0] {
        PH_IDLE  = 3'b001,
        PH_BURST = 3'b010,
        PH_PAUSE = 3'b100
    } dhp_phase_e;
endpackage

// ---- hdl/dhp_burst_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module dhp_burst_timer #(
    parameter int unsigned CYCLES = dhp_pkg::BURST_CYC
) (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic ce_in,
    input  wire logic start_in,
    input  wire logic double_in,
    output logic      burst_out,
    output logic      done_out
);
    import dhp_pkg::*;

    localparam logic [CNT_W-1:0] LEN1 = CNT_W'(CYCLES);
    localparam logic [CNT_W-1:0] LEN2 = CNT_W'(CYCLES * 2);

    dhp_phase_e       phase_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] last_cnt;
    logic             at_end;

    // length tracks the mode live, so a mode change mid-burst stretches or cuts short the current phase
    assign last_cnt = (double_in ? LEN2 : LEN1) - CNT_W'(1);
    assign at_end   = (cnt_reg >= last_cnt);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            phase_reg <= PH_IDLE;
            cnt_reg   <= '0;
        end else if (ce_in) begin
            if (start_in) begin
                phase_reg <= PH_BURST;
                cnt_reg   <= '0;
            end else begin
                case (phase_reg)
                    PH_BURST: begin
                        cnt_reg <= at_end ? '0 : cnt_reg + CNT_W'(1);
                        if (at_end) begin
                            phase_reg <= PH_PAUSE;
                        end
                    end
                    PH_PAUSE: begin
                        cnt_reg <= at_end ? '0 : cnt_reg + CNT_W'(1);
                        if (at_end) begin
                            phase_reg <= PH_IDLE;
                        end
                    end
                    default: begin
                        phase_reg <= PH_IDLE;
                        cnt_reg   <= '0;
                    end
                endcase
            end
        end
    end

    assign burst_out = (phase_reg == PH_BURST);
    assign done_out  = ce_in && !start_in && (phase_reg == PH_PAUSE) && at_end;

    chk_burst_count: assert property (@(posedge clk_in) disable iff (rst_in)
        (phase_reg != PH_IDLE) |-> cnt_reg < LEN2)
        else $error("burst counter ran past its interval");
    chk_pause_follows: assert property (@(posedge clk_in) disable iff (rst_in)
        (ce_in && !start_in && burst_out && at_end) |=> (phase_reg == PH_PAUSE))
        else $error("pause did not follow burst");
    cov_pause_done: cover property (@(posedge clk_in) disable iff (rst_in) done_out);
endmodule
`default_nettype wire

// ---- verif/dhp_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dhp_host_model (
    input  wire logic                   clk_in,
    output logic                        cs_n_out,
    output logic                        rs_out,
    output logic                        wr_n_out,
    output logic                        rd_n_out,
    output logic      [dhp_pkg::DW-1:0] data_out
);
    import dhp_pkg::*;
    // strobes idle high so the first access after reset is a clean edge
    initial begin
        cs_n_out = 1'b1;
        rs_out   = 1'b0;
        wr_n_out = 1'b1;
        rd_n_out = 1'b1;
        data_out = 4'h0;
    end
    // one strobe cycle per write, no wait states sampled
    task automatic wr(input logic rs, input logic [DW-1:0] d);
        @(negedge clk_in);
        cs_n_out = 1'b0;
        rs_out   = rs;
        wr_n_out = 1'b0;
        data_out = d;
        @(negedge clk_in);
        wr_n_out = 1'b1;
        cs_n_out = 1'b1;
        data_out = ~d;
        @(negedge clk_in);
    endtask
    task automatic rd(input logic rs);
        @(negedge clk_in);
        cs_n_out = 1'b0;
        rs_out   = rs;
        rd_n_out = 1'b0;
        repeat (3) @(negedge clk_in);
        rd_n_out = 1'b1;
        cs_n_out = 1'b1;
    endtask
    // software reset of both control banks at program start
    task automatic sw_reset;
        wr(1'b1, 4'h0);
        wr(1'b1, 4'h8);
        wr(1'b1, 4'h0);
    endtask
endmodule
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dhp_pkg::*;
    localparam int unsigned N = 20;
    logic          clk      = 1'b0;
    logic          rst      = 1'b1;
    logic          rx_valid = 1'b0;
    logic          ce       = 1'b1;
    logic          steer    = 1'b0;
    logic          cp_sq    = 1'b1;
    logic [DW-1:0] rx_code  = 4'h0;
    logic          cs_n, rs, wr_n, rd_n, oe, pin_oe, pin_d, tone_on, single, column, det_en;
    logic [DW-1:0] bus_d, rd_d, tone_code, code, code2;
    logic [DW-1:0] exp_q[$];
    int            failures = 0;
    int            n_tests  = 0;
    int            oe_cnt   = 0;
    int            run      = 0;
    int            last_run = 0;
    int            k;

    always #50 clk = ~clk;

    dhp_host_model dhp_host_model_inst (.clk_in(clk), .cs_n_out(cs_n), .rs_out(rs),
        .wr_n_out(wr_n), .rd_n_out(rd_n), .data_out(bus_d));

    dhp_host_port #(.BURST_CYCLES(N)) dhp_host_port_inst (
        .CORE_CLK_IN(clk), .RST_IN(rst), .CLK_EN_IN(ce), .CS_N_IN(cs_n),
        .REGISTER_SELECT_LINE_IN(rs), .WR_N_IN(wr_n), .RD_N_IN(rd_n), .DATA_IN(bus_d),
        .DATA_OUT(rd_d), .DATA_OE_OUT(oe), .RX_VALID_IN(rx_valid), .RX_CODE_IN(rx_code),
        .DELAYED_STEER_IN(steer), .CP_SQUARE_IN(cp_sq), .EVENT_OR_TONE_PIN_OUT(pin_d),
        .EVENT_OR_TONE_PIN_OE_OUT(pin_oe), .TONE_CODE_OUT(tone_code),
        .TONE_OUTPUT_ON_OUT(tone_on), .SINGLE_TONE_OUT(single), .COLUMN_SEL_OUT(column),
        .DETECT_EN_OUT(det_en));

    task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: value %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_len(input int got, input int exp);
        n_tests++;
        if (got != exp) begin
            failures++;
            $display("Error at %0t: length %0d expected %0d", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        // a read whose data never showed leaves its note behind
        if (exp_q.size() != 0)
            failures++;
        $display("Compares %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // read results are judged where the data bus is driven, oldest note first
    always @(negedge clk) begin
        oe_cnt = (oe === 1'b1) ? oe_cnt + 1 : 0;
        if (oe_cnt == 2 && exp_q.size() > 0)
            chk(rd_d, exp_q.pop_front());
        if (tone_on === 1'b1)
            run++;
        else begin
            if (run != 0)
                last_run = run;
            run = 0;
        end
    end

    task automatic rd(input logic r, input logic [DW-1:0] e);
        exp_q.push_back(e);
        dhp_host_model_inst.rd(r);
    endtask
    task automatic wait_fall;
        for (k = 0; k < 300 && !(last_run != 0 && tone_on === 1'b0); k++) @(negedge clk);
    endtask
    task automatic wait_pin;
        for (k = 0; k < 100 && pin_oe !== 1'b1; k++) @(negedge clk);
    endtask
    task automatic pulse_rx(input logic [DW-1:0] c);
        @(negedge clk);
        rx_valid = 1'b1;
        rx_code  = c;
        @(negedge clk);
        rx_valid = 1'b0;
        rx_code  = ~c;
    endtask

    initial begin
        #2_000_000;
        failures++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'he1189e4b));
        steer = 1'($urandom);
        repeat (8) @(posedge clk);
        @(negedge clk);
        chk({oe, pin_oe, tone_on, det_en}, 4'h0);
        rst = 1'b0;
        rd(1'b1, {steer, 3'b000});
        dhp_host_model_inst.sw_reset();
        rd(1'b1, {steer, 3'b000});
        // dtmf burst with interrupt
        dhp_host_model_inst.wr(1'b1, 4'h5);
        code = 4'($urandom);
        last_run = 0;
        dhp_host_model_inst.wr(1'b0, code);
        chk(tone_code, code);
        wait_fall();
        chk_len(last_run, N);
        wait_pin();
        // pause of equal length, then ready flag drives the pin low
        chk_len((k >= N - 3 && k <= N + 1) ? N : k, N);
        rd(1'b1, {steer, 3'b011});
        @(negedge clk);
        chk({3'b000, pin_oe}, 4'h0);
        chk(tone_code, code);
        // call-progress burst: doubled, receive ignored
        dhp_host_model_inst.wr(1'b1, 4'h7);
        chk({3'b000, det_en}, 4'h0);
        cp_sq = 1'b0;
        repeat (3) @(negedge clk);
        chk({3'b000, pin_oe}, 4'h1);
        cp_sq = 1'b1;
        repeat (3) @(negedge clk);
        chk({3'b000, pin_oe}, 4'h0);
        pulse_rx(4'($urandom));
        last_run = 0;
        dhp_host_model_inst.wr(1'b0, ~code);
        wait_fall();
        chk_len(last_run, 2 * N);
        repeat (2 * N + 5) @(negedge clk);
        rd(1'b1, {steer, 3'b011});
        // dtmf receive path
        dhp_host_model_inst.wr(1'b1, 4'h4);
        chk({3'b000, det_en}, 4'h1);
        code2 = 4'($urandom);
        pulse_rx(code2);
        repeat (2) @(negedge clk);
        chk({3'b000, pin_oe}, 4'h1);
        rd(1'b1, {steer, 3'b101});
        rd(1'b0, code2);
        // tone output bit gates a burst
        last_run = 0;
        dhp_host_model_inst.wr(1'b0, code);
        repeat (N + 5) @(negedge clk);
        chk_len(last_run + run, 0);
        // bank steering, single tone, burst disabled
        dhp_host_model_inst.wr(1'b1, 4'h8);
        dhp_host_model_inst.wr(1'b1, 4'hd);
        repeat (2) @(negedge clk);
        chk({2'b00, single, column}, 4'h3);
        dhp_host_model_inst.wr(1'b1, 4'h1);
        repeat (3 * N) @(negedge clk);
        chk({2'b00, tone_on, single}, 4'h3);
        dhp_host_model_inst.wr(1'b1, 4'h0);
        repeat (2) @(negedge clk);
        chk({3'b000, tone_on}, 4'h0);
        // test mode mirrors delayed steering on the pin; the pin data stays low
        dhp_host_model_inst.wr(1'b1, 4'h8);
        dhp_host_model_inst.wr(1'b1, 4'h2);
        repeat (2) @(negedge clk);
        chk({pin_d, single, column, pin_oe}, {3'b000, ~steer});
        steer = ~steer;
        repeat (2) @(negedge clk);
        chk({3'b000, pin_oe}, {3'b000, ~steer});
        // clock enable low freezes every register, the pin and the receive path
        ce = 1'b0;
        steer = ~steer;
        pulse_rx(~code2);
        repeat (2) @(negedge clk);
        chk({3'b000, pin_oe}, {3'b000, steer});
        ce = 1'b1;
        rd(1'b0, code2);
        rd(1'b1, {steer, 3'b000});
        repeat (4) @(negedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
